// ### vci_pkg.sv
// Constants and types shared by the voltage command interpreter files
package vci_pkg;

   // ----------------------------------------------------------------
   // Link frame layout
   // ----------------------------------------------------------------
   localparam logic [2:0] FRAME_START      = 3'h2;
   localparam logic [2:0] HUNT_IDLE        = 3'h7;
   localparam int         FRAME_BODY_BITS  = 17;
   localparam logic [4:0] FRAME_LAST_BIT   = 5'h10;
   localparam int         ADDR_MSB         = 16;
   localparam int         ADDR_LSB         = 13;
   localparam int         CMD_MSB          = 12;
   localparam int         CMD_LSB          = 8;
   localparam int         REPLY_BITS       = 10;
   localparam logic [3:0] REPLY_LAST       = 4'ha;

   // ----------------------------------------------------------------
   // Bus addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_REG_FIRST   = 4'h0;
   localparam logic [3:0] ADDR_REG_SECOND  = 4'h1;
   localparam logic [3:0] ADDR_BCAST_A     = 4'hf;
   localparam logic [3:0] ADDR_BCAST_B     = 4'he;

   // ----------------------------------------------------------------
   // Command codes and acknowledge codes
   // ----------------------------------------------------------------
   localparam logic [4:0] CMD_TARGET_FAST  = 5'h01;
   localparam logic [4:0] CMD_TARGET_SLOW  = 5'h02;
   localparam logic [4:0] CMD_TARGET_DECAY = 5'h03;
   localparam logic [4:0] CMD_POWER_STATE  = 5'h04;
   localparam logic [4:0] CMD_REG_POINTER  = 5'h05;
   localparam logic [4:0] CMD_REG_WRITE    = 5'h06;
   localparam logic [4:0] CMD_REG_READ     = 5'h07;
   localparam logic [1:0] ACK_OK           = 2'h2;
   localparam logic [1:0] ACK_NAK          = 2'h1;
   localparam logic [1:0] ACK_REJECT       = 2'h3;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_FAST_RAMP_RATE = 8'h24;
   localparam logic [7:0] REG_SLOW_RAMP_RATE = 8'h25;
   localparam logic [7:0] FAST_RATE_RST      = 8'h0a;
   localparam logic [7:0] POINTER_RST        = 8'h00;

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   localparam logic [7:0] PS_FULL_POWER    = 8'h00;
   localparam logic [7:0] PS_FULL_ONEHOT   = 8'h01;
   localparam logic [7:0] PS_ONE_PHASE     = 8'h02;
   localparam logic [7:0] PS_SKIP          = 8'h04;
   localparam logic [7:0] PS_LOWEST        = 8'h04;
   localparam int         PS_SKIP_BIT      = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         CLK_PERIOD_NS    = 50;
   localparam int         RATE_TICK_NS     = 1000;
   localparam int         RATE_TICK_CYC    = RATE_TICK_NS / CLK_PERIOD_NS;
   localparam logic [4:0] RATE_TICK_LAST   = 5'(RATE_TICK_CYC - 1);
   localparam logic [4:0] STRAP_SYNC_LAST  = 5'h02;
   localparam logic [9:0] VID_STEP_MV      = 10'h005;
   localparam logic [9:0] VID_STEP_MV_SLOW = 10'h014;
   localparam logic [7:0] VID_RST          = 8'h00;

   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_IDLE, MODE_FAST, MODE_SLOW, MODE_DECAY} vci_mode_t;
   typedef enum logic {RX_HUNT, RX_BODY} vci_rx_t;

endpackage

// ### vci_link_rx.sv
// Link pin synchroniser, edge finder and command frame receiver
`timescale 1ns/100ps
module vci_link_rx
   import vci_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        sclk_pin,
   input  wire logic        sdio_pin,
   input  wire logic        hold,
   output logic             sclk_rise,
   output logic             sclk_fall,
   output logic             frame_valid,
   output logic [16:0]      frame_bits
);

   typedef struct packed {
      logic        sclk_s1;
      logic        sclk_s2;
      logic        sclk_s3;
      logic        sdio_s1;
      logic        sdio_s2;
      vci_rx_t     state;
      logic [2:0]  hunt;
      logic [4:0]  cnt;
      logic [16:0] shift;
      logic        valid;
      logic [16:0] bits;
   } vci_rx_state_t;

   vci_rx_state_t s_q;
   vci_rx_state_t s_d;
   logic          rise;
   logic [2:0]    hunt_next;

   assign rise        = s_q.sclk_s2 & ~s_q.sclk_s3;
   assign hunt_next   = {s_q.hunt[1:0], s_q.sdio_s2};
   assign sclk_rise   = rise;
   assign sclk_fall   = ~s_q.sclk_s2 & s_q.sclk_s3;
   assign frame_valid = s_q.valid;
   assign frame_bits  = s_q.bits;

   // ----------------------------------------------------------------
   // Frame capture
   // ----------------------------------------------------------------
   always_comb begin
      s_d         = s_q;
      s_d.sclk_s1 = sclk_pin;
      s_d.sclk_s2 = s_q.sclk_s1;
      s_d.sclk_s3 = s_q.sclk_s2;
      s_d.sdio_s1 = sdio_pin;
      s_d.sdio_s2 = s_q.sdio_s1;
      s_d.valid   = 1'b0;
      if (hold) begin
         s_d.state = RX_HUNT;
         s_d.hunt  = HUNT_IDLE;
      end else if (rise) begin
         unique case (s_q.state)
            RX_HUNT: begin
               s_d.hunt = hunt_next;
               if (hunt_next == FRAME_START) begin
                  s_d.state = RX_BODY;
                  s_d.cnt   = 5'h00;
               end
            end
            RX_BODY: begin
               s_d.shift = {s_q.shift[15:0], s_q.sdio_s2};
               s_d.cnt   = s_q.cnt + 5'h01;
               if (s_q.cnt == FRAME_LAST_BIT) begin
                  s_d.bits  = {s_q.shift[15:0], s_q.sdio_s2};
                  s_d.valid = 1'b1;
                  s_d.state = RX_HUNT;
                  s_d.hunt  = HUNT_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q      <= '0;
         // Hunt starts at the idle-high wire level so no false start follows
         s_q.hunt <= HUNT_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ### vci_core.sv
// Voltage command interpreter: decode, ramp engine, power state and reply
`timescale 1ns/100ps
// Summary of operation
// - Broadcast addresses 1111b and 1110b also accepted
// - Code 01h ramps at fast rate
// - New target aborts ramp at once
// - Back-to-back target releases attention after ack
// - Same target asserts attention after ack
// - Upward target forces full-power state
// - Fast or slow ramp arrival sets settled flag, attention low
// - Code 02h ramps at quarter rate
// - Code 03h uncontrolled, settled, attention stays high
// - Decay preempts rising fast or slow ramp
// - Decay above setting rejected, target kept
// - Code 04h payload selects power state
// - Unsupported state gets NAK, lowest state
// - New power state only after ack
// - Upward target clears power state to 00h
// - Power state never preempts other work
// - Power state during controlled ramp rejected
// - Power state accepted during decay descent
// - Code 05h loads register pointer
// - Code 06h acknowledged, no register written
// - Code 07h returns named register contents
// - Fixed bus address 0 or 1
// - Unsupported register index rejected
module vci_core
   import vci_pkg::*;
#(
   parameter logic [3:0] BUS_ADDR = ADDR_REG_FIRST
)
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   input  wire logic        SCLK,
   input  wire logic        SDIO_IN,
   output logic             SDIO_OUT,
   output logic             SDIO_OE,
   output logic             ALERT_N,
   input  wire logic [7:0]  RAMP_STRAP_PIN,
   output logic [7:0]       VID_DAC,
   output logic [7:0]       TARGET_VID,
   output logic             OUTPUT_SETTLED_FLAG,
   output logic [7:0]       POWER_STATE,
   output logic             MULTIPHASE_EN,
   output logic             PULSE_SKIP_EN
);

   typedef struct packed {
      logic [7:0]  strap_s1;
      logic [7:0]  strap_s2;
      logic        strap_done;
      logic [7:0]  fast_rate;
      logic [4:0]  tick_cnt;
      logic        tick;
      logic [9:0]  acc;
      logic [7:0]  vid;
      logic [7:0]  target;
      vci_mode_t   mode;
      logic        settled;
      logic        alert_n;
      logic [7:0]  ps;
      logic [7:0]  ps_pend;
      logic [7:0]  ptr;
      logic        act_alert_rel;
      logic        act_alert_set;
      logic        act_ps_clr;
      logic        act_ps_load;
      logic        rbusy;
      logic [3:0]  rcnt;
      logic [9:0]  rshift;
      logic        sdio_out;
      logic        sdio_oe;
   } vci_core_state_t;

   vci_core_state_t s_q;
   vci_core_state_t s_d;
   logic            sclk_rise;
   logic            sclk_fall;
   logic            frame_valid;
   logic [16:0]     frame_bits;
   logic [3:0]      f_addr;
   logic [4:0]      f_cmd;
   logic [7:0]      f_pay;
   logic            addr_hit;
   logic            bcast;
   logic [1:0]      ack;
   logic [7:0]      rdata;
   logic [9:0]      step_thr;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic reg_supported(input logic [7:0] idx);
      reg_supported = (idx == REG_FAST_RAMP_RATE) || (idx == REG_SLOW_RAMP_RATE);
   endfunction

   function automatic logic [7:0] reg_value(input logic [7:0] idx, input logic [7:0] fast);
      reg_value = (idx == REG_FAST_RAMP_RATE) ? fast : {2'h0, fast[7:2]};
   endfunction

   function automatic logic ps_supported(input logic [7:0] p);
      ps_supported = (p == PS_FULL_POWER) || (p == PS_FULL_ONEHOT) || (p == PS_ONE_PHASE) || (p == PS_SKIP);
   endfunction

   // ----------------------------------------------------------------
   // Link receiver
   // ----------------------------------------------------------------
   vci_link_rx u_rx (
      .clk         (CORE_CLK),
      .rst_b       (RST_B),
      .sclk_pin    (SCLK),
      .sdio_pin    (SDIO_IN),
      .hold        (s_q.rbusy),
      .sclk_rise   (sclk_rise),
      .sclk_fall   (sclk_fall),
      .frame_valid (frame_valid),
      .frame_bits  (frame_bits)
   );

   assign f_addr   = frame_bits[ADDR_MSB:ADDR_LSB];
   assign f_cmd    = frame_bits[CMD_MSB:CMD_LSB];
   assign f_pay    = frame_bits[7:0];
   assign bcast    = (f_addr == ADDR_BCAST_A) || (f_addr == ADDR_BCAST_B);
   assign addr_hit = bcast || (f_addr == BUS_ADDR);
   assign step_thr = (s_q.mode == MODE_SLOW) ? VID_STEP_MV_SLOW : VID_STEP_MV;

   // ----------------------------------------------------------------
   // Acknowledge and read data
   // ----------------------------------------------------------------
   always_comb begin
      ack   = ACK_REJECT;
      rdata = 8'h00;
      unique case (f_cmd)
         CMD_TARGET_FAST,
         CMD_TARGET_SLOW: begin
            ack = ACK_OK;
         end
         CMD_TARGET_DECAY: begin
            ack = (f_pay > s_q.target) ? ACK_REJECT : ACK_OK;
         end
         CMD_POWER_STATE: begin
            if (s_q.mode == MODE_FAST || s_q.mode == MODE_SLOW) begin
               ack = ACK_REJECT;
            end else begin
               ack = ps_supported(f_pay) ? ACK_OK : ACK_NAK;
            end
         end
         CMD_REG_POINTER,
         CMD_REG_READ: begin
            if (bcast) begin
               ack = ACK_NAK;
            end else if (reg_supported(f_pay)) begin
               ack = ACK_OK;
            end
            if (f_cmd == CMD_REG_READ && !bcast && reg_supported(f_pay)) begin
               rdata = reg_value(f_pay, s_q.fast_rate);
            end
         end
         CMD_REG_WRITE: begin
            ack = bcast ? ACK_NAK : ACK_OK;
         end
         default: begin
            ack = ACK_REJECT;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.strap_s1 = RAMP_STRAP_PIN;
      s_d.strap_s2 = s_q.strap_s1;
      s_d.tick     = 1'b0;

      // Strap caught once after reset release
      if (!s_q.strap_done && s_q.tick_cnt == STRAP_SYNC_LAST) begin
         s_d.strap_done = 1'b1;
         s_d.fast_rate  = s_q.strap_s2;
      end

      // Microsecond rate tick
      if (s_q.tick_cnt == RATE_TICK_LAST) begin
         s_d.tick_cnt = 5'h00;
         s_d.tick     = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 5'h01;
      end

      // Ramp engine
      unique case (s_q.mode)
         MODE_IDLE: begin
            s_d.acc = 10'h000;
         end
         MODE_FAST,
         MODE_SLOW: begin
            if (s_q.tick) begin
               s_d.acc = s_q.acc + {2'h0, s_q.fast_rate};
            end else if (s_q.vid == s_q.target) begin
               s_d.mode    = MODE_IDLE;
               s_d.settled = 1'b1;
               s_d.alert_n = 1'b0;
            end else if (s_q.acc >= step_thr) begin
               s_d.acc = s_q.acc - step_thr;
               s_d.vid = (s_q.vid < s_q.target) ? s_q.vid + 8'h01 : s_q.vid - 8'h01;
            end
         end
         MODE_DECAY: begin
            if (s_q.vid <= s_q.target) begin
               s_d.vid     = s_q.target;
               s_d.mode    = MODE_IDLE;
               s_d.settled = 1'b1;
            end else if (s_q.tick) begin
               s_d.vid = s_q.vid - 8'h01;
            end
         end
      endcase

      // Command registration
      if (frame_valid && addr_hit) begin
         s_d.act_alert_rel = 1'b0;
         s_d.act_alert_set = 1'b0;
         s_d.act_ps_clr    = 1'b0;
         s_d.act_ps_load   = 1'b0;
         s_d.rbusy         = 1'b1;
         s_d.rcnt          = 4'h0;
         s_d.rshift        = {ack, rdata};
         unique case (f_cmd)
            CMD_TARGET_FAST,
            CMD_TARGET_SLOW: begin
               s_d.target        = f_pay;
               s_d.acc           = 10'h000;
               s_d.settled       = 1'b0;
               s_d.act_alert_rel = 1'b1;
               if (f_pay == s_q.vid) begin
                  s_d.mode          = MODE_IDLE;
                  s_d.act_alert_set = 1'b1;
               end else begin
                  s_d.mode = (f_cmd == CMD_TARGET_FAST) ? MODE_FAST : MODE_SLOW;
               end
               if (f_pay > s_q.vid) begin
                  s_d.act_ps_clr = 1'b1;
               end
            end
            CMD_TARGET_DECAY: begin
               if (ack == ACK_OK) begin
                  s_d.target        = f_pay;
                  s_d.mode          = MODE_DECAY;
                  s_d.settled       = 1'b0;
                  s_d.act_alert_rel = 1'b1;
               end
            end
            CMD_POWER_STATE: begin
               if (ack != ACK_REJECT) begin
                  s_d.act_ps_load = 1'b1;
                  s_d.ps_pend     = (ack == ACK_OK) ? f_pay : PS_LOWEST;
               end
            end
            CMD_REG_POINTER: begin
               if (ack == ACK_OK) begin
                  s_d.ptr = f_pay;
               end
            end
            CMD_REG_WRITE: begin
               s_d.ptr = s_q.ptr;
            end
            default: begin
               s_d.rshift = {ack, rdata};
            end
         endcase
      end

      // Reply shifter, bits change on falling link clock
      if (s_q.rbusy && sclk_fall) begin
         if (s_q.rcnt == REPLY_LAST) begin
            s_d.rbusy   = 1'b0;
            s_d.sdio_oe = 1'b0;
            if (s_q.act_alert_rel && !s_q.settled) begin
               s_d.alert_n = 1'b1;
            end
            if (s_q.act_alert_set) begin
               s_d.settled = 1'b1;
               s_d.alert_n = 1'b0;
            end
            if (s_q.act_ps_clr) begin
               s_d.ps = PS_FULL_POWER;
            end
            if (s_q.act_ps_load && s_q.mode != MODE_FAST && s_q.mode != MODE_SLOW) begin
               s_d.ps = s_q.ps_pend;
            end
            s_d.act_alert_rel = 1'b0;
            s_d.act_alert_set = 1'b0;
            s_d.act_ps_clr    = 1'b0;
            s_d.act_ps_load   = 1'b0;
         end else begin
            s_d.sdio_oe  = 1'b1;
            s_d.sdio_out = s_q.rshift[REPLY_BITS-1];
            s_d.rshift   = {s_q.rshift[8:0], 1'b0};
            s_d.rcnt     = s_q.rcnt + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_q           <= '0;
         s_q.fast_rate <= FAST_RATE_RST;
         s_q.vid       <= VID_RST;
         s_q.target    <= VID_RST;
         s_q.mode      <= MODE_IDLE;
         s_q.alert_n   <= 1'b1;
         s_q.ps        <= PS_FULL_POWER;
         s_q.ptr       <= POINTER_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign SDIO_OUT            = s_q.sdio_out;
   assign SDIO_OE             = s_q.sdio_oe;
   assign ALERT_N             = s_q.alert_n;
   assign VID_DAC             = s_q.vid;
   assign TARGET_VID          = s_q.target;
   assign OUTPUT_SETTLED_FLAG = s_q.settled;
   assign POWER_STATE         = s_q.ps;
   assign MULTIPHASE_EN       = (s_q.ps == PS_FULL_POWER) || (s_q.ps == PS_FULL_ONEHOT);
   assign PULSE_SKIP_EN       = s_q.ps[PS_SKIP_BIT];

endmodule

// ### vci_chk.sv
// Port assertions for the voltage command interpreter
`timescale 1ns/100ps
module vci_chk
   import vci_pkg::*;
(
   input wire logic       CORE_CLK,
   input wire logic       RST_B,
   input wire logic       SDIO_OE,
   input wire logic       ALERT_N,
   input wire logic [7:0] VID_DAC,
   input wire logic [7:0] TARGET_VID,
   input wire logic       OUTPUT_SETTLED_FLAG,
   input wire logic [7:0] POWER_STATE,
   input wire logic       MULTIPHASE_EN,
   input wire logic       PULSE_SKIP_EN
);
   logic [7:0] oe_cnt_q;

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   // ----------------------------------------
   // Reply length counter
   // ----------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         oe_cnt_q <= 8'h00;
      end else begin
         oe_cnt_q <= SDIO_OE ? oe_cnt_q + 8'h01 : 8'h00;
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_phase; MULTIPHASE_EN == (POWER_STATE < 8'h02); endproperty
   a_phase: assert property (p_phase) else $error("phase enable wrong");
   property p_skip; PULSE_SKIP_EN == POWER_STATE[2]; endproperty
   a_skip: assert property (p_skip) else $error("skip enable wrong");
   property p_arrive; $rose(OUTPUT_SETTLED_FLAG) |-> VID_DAC == TARGET_VID; endproperty
   a_arrive: assert property (p_arrive) else $error("settled off target");
   property p_alert; $fell(ALERT_N) |-> OUTPUT_SETTLED_FLAG && VID_DAC == TARGET_VID; endproperty
   a_alert: assert property (p_alert) else $error("alert before arrival");
   property p_up; VID_DAC > $past(VID_DAC) |-> VID_DAC <= TARGET_VID || VID_DAC <= $past(TARGET_VID); endproperty
   a_up: assert property (p_up) else $error("ramp passed target");
   property p_oe_len; $fell(SDIO_OE) |-> $past(oe_cnt_q) inside {[8'h4e:8'h52]}; endproperty
   a_oe_len: assert property (p_oe_len) else $error("reply length wrong");
   property p_ps_up;
      $changed(TARGET_VID) && TARGET_VID > $past(VID_DAC) |-> ##[1:100] POWER_STATE == 8'h00;
   endproperty
   a_ps_up: assert property (p_ps_up) else $error("no full power on rise");
   property p_ps_ack; $changed(POWER_STATE) |-> !SDIO_OE; endproperty
   a_ps_ack: assert property (p_ps_ack) else $error("state changed in reply");
   property p_tgt; $changed(TARGET_VID) |-> !OUTPUT_SETTLED_FLAG ##[1:16] SDIO_OE; endproperty
   a_tgt: assert property (p_tgt) else $error("target change wrong");

   c_settle: cover property ($rose(OUTPUT_SETTLED_FLAG));
   c_alert: cover property ($fell(ALERT_N));
   c_lowest: cover property (POWER_STATE == 8'h04);
endmodule

bind vci_core vci_chk u_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .SDIO_OE(SDIO_OE), .ALERT_N(ALERT_N),
   .VID_DAC(VID_DAC), .TARGET_VID(TARGET_VID), .OUTPUT_SETTLED_FLAG(OUTPUT_SETTLED_FLAG),
   .POWER_STATE(POWER_STATE), .MULTIPHASE_EN(MULTIPHASE_EN), .PULSE_SKIP_EN(PULSE_SKIP_EN));

// ### vci_master.sv
// Link master model: sends frames and collects replies
`timescale 1ns/100ps
module vci_master (
   output logic      sclk,
   output logic      sdio_in,
   input  wire logic sdio_out,
   input  wire logic sdio_oe
);
   logic drv_q;
   logic bit_q;

   // Wire level: device, then master, else pull-up
   assign sdio_in = sdio_oe ? sdio_out : (drv_q ? bit_q : 1'b1);

   initial begin
      sclk = 1'b1;
      drv_q = 1'b0;
      bit_q = 1'b1;
   end

   task automatic frame(input logic [16:0] word, output logic [9:0] reply);
      logic [19:0] bits;
      bits = {3'h2, word};
      reply = 10'h000;
      for (int i = 0; i < 31; i++) begin
         sclk = 1'b0;
         drv_q = (i < 20);
         bit_q = (i < 20) ? bits[19 - i] : 1'b1;
         #200;
         sclk = 1'b1;
         #200;
         if (i >= 20 && i < 30) begin
            reply = {reply[8:0], sdio_in};
         end
      end
   endtask
endmodule

// ### vci_core_test.sv
// Self-checking bench for the voltage command interpreter
`timescale 1ns/100ps
module vci_core_test
   import vci_pkg::*;
;
   localparam logic [3:0] ME  = ADDR_REG_FIRST;
   localparam logic [9:0] OK  = 10'h200;
   localparam logic [9:0] NAK = 10'h100;
   localparam logic [9:0] REJ = 10'h300;
   logic       core_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] strap = 8'h0a;
   logic       sclk;
   logic       sdio_in;
   logic       sdio_out;
   logic       sdio_oe;
   logic       alert_n;
   logic       settled;
   logic       mph;
   logic       skip;
   logic [7:0] vid;
   logic [7:0] tgt;
   logic [7:0] ps;
   logic [7:0] ps_ok [4] = '{8'h01, 8'h02, 8'h04, 8'h00};
   logic [4:0] rej [4] = '{5'h00, 5'h08, 5'h09, 5'h1f};
   int         failures = 0;
   int         tests_run = 0;
   int         n;

   always #25 core_clk = ~core_clk;

   vci_core u_dut (.CORE_CLK(core_clk), .RST_B(rst_b), .SCLK(sclk), .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out),
      .SDIO_OE(sdio_oe), .ALERT_N(alert_n), .RAMP_STRAP_PIN(strap), .VID_DAC(vid), .TARGET_VID(tgt),
      .OUTPUT_SETTLED_FLAG(settled), .POWER_STATE(ps), .MULTIPHASE_EN(mph), .PULSE_SKIP_EN(skip));
   vci_master u_master (.sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         failures++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic op(input logic [3:0] a, input logic [4:0] c, input logic [7:0] p, input logic [9:0] exp);
      logic [9:0] r;
      u_master.frame({a, c, p}, r);
      check(r === exp, "reply mismatch");
   endtask

   task automatic settle();
      n = 0;
      while (settled !== 1'b1 && n < 4000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 4000) begin
         check(1'b0, "settle timeout");
         summarize();
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      check(alert_n === 1'b1 && vid === 8'h00 && ps === 8'h00 && mph === 1'b1, "reset state");
      op(ME, 5'h07, 8'h24, OK | 10'h00a);
      op(ME, 5'h07, 8'h25, OK | 10'h002);
      op(ME, 5'h07, 8'h00, REJ);
      op(ME, 5'h05, 8'h30, REJ);
      op(ME, 5'h05, 8'h24, OK);
      op(ME, 5'h06, 8'h55, OK);
      op(ME, 5'h06, 8'h66, OK);
      op(ME, 5'h07, 8'h24, OK | 10'h00a);
      op(ADDR_BCAST_A, 5'h07, 8'h24, NAK);
      op(ADDR_BCAST_B, 5'h05, 8'h24, NAK);
      op(ADDR_REG_SECOND, 5'h07, 8'h24, 10'h3ff);
      foreach (rej[i]) op(ME, rej[i], 8'h00, REJ);
      op(ME, 5'h01, 8'h40, OK);
      check(tgt === 8'h40 && settled === 1'b0 && alert_n === 1'b1, "fast start");
      settle();
      check(n > 510 && n < 600 && vid === 8'h40 && alert_n === 1'b0, "fast ramp");
      op(ME, 5'h02, 8'h60, OK);
      settle();
      check(n > 1140 && n < 1240 && vid === 8'h60, "slow ramp");
      op(ME, 5'h01, 8'h60, OK);
      check(alert_n === 1'b0 && settled === 1'b1, "same target");
      foreach (ps_ok[i]) begin
         op(ME, 5'h04, ps_ok[i], OK);
         check(ps === ps_ok[i] && mph === (ps_ok[i] < 8'h02) && skip === ps_ok[i][2], "state");
      end
      op(ME, 5'h04, 8'h40, NAK);
      check(ps === PS_LOWEST && skip === 1'b1, "lowest state");
      op(ADDR_BCAST_B, 5'h01, 8'ha0, OK);
      check(ps === 8'h00 && mph === 1'b1 && alert_n === 1'b1, "upward exit");
      op(ME, 5'h04, 8'h02, REJ);
      check(ps === 8'h00, "state kept in ramp");
      op(ME, 5'h03, 8'h50, OK);
      check(tgt === 8'h50 && alert_n === 1'b1, "decay taken");
      op(ME, 5'h04, 8'h02, OK);
      check(ps === 8'h02 && vid !== 8'h50, "state in decay");
      op(ME, 5'h03, 8'hb0, REJ);
      check(tgt === 8'h50, "decay target kept");
      settle();
      check(vid === 8'h50 && alert_n === 1'b1, "decay arrival");
      op(ME, 5'h02, 8'h58, OK);
      check(ps === 8'h00, "slow upward exit");
      settle();
      op(ME, 5'h04, 8'h02, OK);
      check(ps === 8'h02, "state reissued");
      op(ME, 5'h01, 8'h90, OK);
      op(ME, 5'h01, 8'h60, OK);
      check(tgt === 8'h60 && alert_n === 1'b1, "preempt");
      settle();
      check(vid === 8'h60 && alert_n === 1'b0, "preempt arrival");
      summarize();
   end
endmodule
